// File: rtl/ccm_pkg.sv
// ccm_pkg: constants, register map and carrier types of the capture/compare modules.
// assumes a 32-bit AXI4-Lite master with 8-bit byte addresses and one shared 16-bit counter.
package ccm_pkg;

  localparam int NUM_MOD = 5;
  localparam int ADDR_W = 8;

  // register byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] IRQEN_OFS = 8'h04;
  localparam logic [7:0] MODE_BASE = 8'h10;
  localparam logic [7:0] CMPL_BASE = 8'h30;
  localparam logic [7:0] CMPH_BASE = 8'h50;
  localparam logic [7:0] REG_STRIDE = 8'h04;

  // module_mode_reg fields
  localparam int WIDE_PULSE_BIT = 7;
  localparam int COMPARATOR_BIT = 6;
  localparam int RISE_CAP_BIT = 5;
  localparam int FALL_CAP_BIT = 4;
  localparam int MATCH_BIT = 3;
  localparam int TOGGLE_BIT = 2;
  localparam int PULSE_BIT = 1;
  localparam int FLAG_IRQ_BIT = 0;

  // irq_enable_reg fields
  localparam int GLOBAL_IRQ_BIT = 0;
  localparam int ARRAY_IRQ_BIT = 1;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [4:0] FLAG_RST = 5'h00;
  localparam logic [1:0] IRQEN_RST = 2'h0;

  localparam logic [15:0] COUNT_WRAP = 16'h0000;
  localparam logic [7:0] LOW_WRAP = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [6:0] {
    MODE_IDLE = 7'b000_0001,
    MODE_CAPTURE = 7'b000_0010,
    MODE_TIMER = 7'b000_0100,
    MODE_HSO = 7'b000_1000,
    MODE_FREQ = 7'b001_0000,
    MODE_PWM8 = 7'b010_0000,
    MODE_PWM16 = 7'b100_0000
  } ccm_mode_e;

  typedef struct packed {
    logic [15:0] value;
    logic tick;
  } ccm_count_s;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } ccm_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ccm_axil_rsp_s;

endpackage

// File: rtl/ccm_top.sv
// ccm_top: five capture/compare modules on one shared 16-bit counter, AXI4-Lite registers.
// assumes the counter value and its advance tick arrive synchronous to clk.
//
// How it works
// - rise bit alone, fall bit alone, or both select edge capture modes
// - interrupt needs flag, its enable, global enable and array enable
// - valid selected pin edge copies counter into the compare word
// - a capture sets the module event flag
// - flag stays set until software clears it
// - software timer sets the flag on counter equal to compare word
// - low byte write clears comparator enable, high byte write sets it
// - high-speed output toggles pin on every 16-bit match
// - frequency output toggles on low byte match, then adds high byte
// - frequency is timebase over twice high byte; zero acts as 256
// - 8-bit pulse: high on low byte match, low on low byte wrap
// - on low byte wrap the low compare byte reloads from high byte
// - 8-bit duty is 256 minus high byte over 256
// - pulse modes hold the pin low while comparator enable is clear
// - 16-bit pulse: high on full match, low on counter wrap
// - 16-bit duty is 65536 minus compare word over 65536
// - five independent modules share one 16-bit counter
// - counter wrap to zero is the overflow event
// - event flags sit in bits 0 to 4 of the control register
`timescale 1ns/1ps

module ccm_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire ccm_pkg::ccm_axil_req_s bus_req,
  output ccm_pkg::ccm_axil_rsp_s bus_rsp,
  // shared counter
  input wire ccm_pkg::ccm_count_s counter_array,
  // module pins
  input wire logic [ccm_pkg::NUM_MOD-1:0] module_io_pin_in,
  output logic [ccm_pkg::NUM_MOD-1:0] module_io_pin_out,
  output logic [ccm_pkg::NUM_MOD-1:0] module_io_pin_oe_n,
  // interrupt request
  output logic irq_request
);
  import ccm_pkg::*;

  function automatic ccm_mode_e decode_mode(input logic [7:0] m);
    logic capb;
    capb = m[RISE_CAP_BIT] | m[FALL_CAP_BIT];
    decode_mode = MODE_IDLE;
    if (capb && !m[MATCH_BIT] && !m[TOGGLE_BIT] && !m[PULSE_BIT]) begin
      decode_mode = MODE_CAPTURE;
    end else if (!capb) begin
      // pulse modes decode without the comparator so a cleared one gives 0%
      if (m[TOGGLE_BIT] && m[PULSE_BIT] && m[COMPARATOR_BIT]) begin
        decode_mode = MODE_FREQ;
      end else if (m[PULSE_BIT] && !m[TOGGLE_BIT]) begin
        decode_mode = m[WIDE_PULSE_BIT] ? MODE_PWM16 : MODE_PWM8;
      end else if (m[MATCH_BIT] && m[TOGGLE_BIT] && m[COMPARATOR_BIT]) begin
        decode_mode = MODE_HSO;
      end else if (m[MATCH_BIT] && m[COMPARATOR_BIT]) begin
        decode_mode = MODE_TIMER;
      end
    end
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] base,
                               input int idx);
    hit = (a == ADDR_W'(base + 8'(idx) * REG_STRIDE));
  endfunction

  // bus registers
  logic awready;
  logic wready;
  logic bvalid;
  logic [1:0] bresp;
  logic arready;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic wr_fire;
  logic wr_mapped;

  // block state
  logic [7:0] mode [NUM_MOD];
  logic [15:0] cmp [NUM_MOD];
  logic [NUM_MOD-1:0] flag;
  logic [NUM_MOD-1:0] evt;
  logic [1:0] irq_en;
  logic [NUM_MOD-1:0] pin_samp;
  logic [NUM_MOD-1:0] pin_lvl;
  logic [NUM_MOD-1:0] flag_irq;
  logic wr_ctrl;
  logic wr_irqen;
  logic [NUM_MOD-1:0] wr_mode;
  logic [NUM_MOD-1:0] wr_cmpl;
  logic [NUM_MOD-1:0] wr_cmph;
  logic tick;
  logic low_wrap;
  logic full_wrap;

  assign bus_rsp = '{awready: awready, wready: wready, bvalid: bvalid, bresp: bresp,
                     arready: arready, rvalid: rvalid, rdata: rdata, rresp: rresp};

  assign tick = counter_array.tick;
  assign low_wrap = tick && (counter_array.value[7:0] == LOW_WRAP);
  assign full_wrap = tick && (counter_array.value == COUNT_WRAP);

  // write channel: address and data taken in either order, answered together
  assign wr_fire = !awready && !wready && !bvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awready <= 1'b1;
      wr_addr <= '0;
    end else if (awready && bus_req.awvalid) begin
      awready <= 1'b0;
      wr_addr <= bus_req.awaddr;
    end else if (wr_fire) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wready <= 1'b1;
      wr_byte <= '0;
      wr_lane <= 1'b0;
    end else if (wready && bus_req.wvalid) begin
      wready <= 1'b0;
      wr_byte <= bus_req.wdata[7:0];
      wr_lane <= bus_req.wstrb[0];
    end else if (wr_fire) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bus_req.bready) begin
      bvalid <= 1'b0;
    end
  end

  assign wr_ctrl = wr_fire && wr_lane && hit(wr_addr, CTRL_OFS, 0);
  assign wr_irqen = wr_fire && wr_lane && hit(wr_addr, IRQEN_OFS, 0);
  assign wr_mapped = hit(wr_addr, CTRL_OFS, 0) || hit(wr_addr, IRQEN_OFS, 0) ||
                     (|wr_mode_hit(wr_addr));

  function automatic logic [NUM_MOD-1:0] wr_mode_hit(input logic [ADDR_W-1:0] a);
    logic [NUM_MOD-1:0] h;
    h = '0;
    for (int i = 0; i < NUM_MOD; i++) begin
      h[i] = hit(a, MODE_BASE, i) || hit(a, CMPL_BASE, i) ||
             hit(a, CMPH_BASE, i);
    end
    wr_mode_hit = h;
  endfunction

  // read channel: one answer per address, a cycle after it is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arready && bus_req.arvalid) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= 32'h0000_0000;
      rresp <= RESP_SLVERR;
      if (hit(bus_req.araddr, CTRL_OFS, 0)) begin
        rdata <= 32'(flag);
        rresp <= RESP_OKAY;
      end
      if (hit(bus_req.araddr, IRQEN_OFS, 0)) begin
        rdata <= 32'(irq_en);
        rresp <= RESP_OKAY;
      end
      for (int i = 0; i < NUM_MOD; i++) begin
        if (hit(bus_req.araddr, MODE_BASE, i)) begin
          rdata <= 32'(mode[i]);
          rresp <= RESP_OKAY;
        end
        if (hit(bus_req.araddr, CMPL_BASE, i)) begin
          rdata <= 32'(cmp[i][7:0]);
          rresp <= RESP_OKAY;
        end
        if (hit(bus_req.araddr, CMPH_BASE, i)) begin
          rdata <= 32'(cmp[i][15:8]);
          rresp <= RESP_OKAY;
        end
      end
    end else if (rvalid && bus_req.rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_en <= IRQEN_RST;
    end else if (wr_irqen) begin
      irq_en <= wr_byte[1:0];
    end
  end

  // hardware set wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag <= FLAG_RST;
    end else begin
      flag <= (wr_ctrl ? wr_byte[NUM_MOD-1:0] : flag) | evt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= irq_en[GLOBAL_IRQ_BIT] && irq_en[ARRAY_IRQ_BIT] && (|flag_irq);
    end
  end

  // capture pin filter, one sample and one level bit per module pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_samp <= '0;
      pin_lvl <= '0;
    end else begin
      pin_samp <= module_io_pin_in;
      for (int i = 0; i < NUM_MOD; i++) begin
        if (pin_samp[i] == module_io_pin_in[i]) begin
          pin_lvl[i] <= module_io_pin_in[i];
        end
      end
    end
  end

  for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
    ccm_mode_e md;
    logic stable;
    logic rise;
    logic fall;
    logic cap;
    logic match16;
    logic match8;
    logic ecom;

    assign md = decode_mode(mode[g]);
    assign ecom = mode[g][COMPARATOR_BIT];
    assign flag_irq[g] = flag[g] && mode[g][FLAG_IRQ_BIT];
    assign wr_mode[g] = wr_fire && wr_lane && hit(wr_addr, MODE_BASE, g);
    assign wr_cmpl[g] = wr_fire && wr_lane && hit(wr_addr, CMPL_BASE, g);
    assign wr_cmph[g] = wr_fire && wr_lane && hit(wr_addr, CMPH_BASE, g);
    // a level counts once seen at two consecutive edges
    assign stable = (pin_samp[g] == module_io_pin_in[g]);
    assign rise = stable && module_io_pin_in[g] && !pin_lvl[g];
    assign fall = stable && !module_io_pin_in[g] && pin_lvl[g];
    assign cap = (md == MODE_CAPTURE) && ((rise && mode[g][RISE_CAP_BIT]) ||
                                         (fall && mode[g][FALL_CAP_BIT]));
    assign match16 = tick && (counter_array.value == cmp[g]);
    assign match8 = tick && (counter_array.value[7:0] == cmp[g][7:0]);
    assign evt[g] = cap || (ecom && mode[g][MATCH_BIT] &&
                    ((md == MODE_TIMER || md == MODE_HSO) ? match16 :
                     (md == MODE_PWM16) ? match16 : (md == MODE_FREQ || md == MODE_PWM8) &&
                     match8));

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        mode[g] <= MODE_RST;
      end else if (wr_mode[g]) begin
        mode[g] <= wr_byte;
      end else if (wr_cmpl[g]) begin
        mode[g][COMPARATOR_BIT] <= 1'b0;
      end else if (wr_cmph[g]) begin
        mode[g][COMPARATOR_BIT] <= 1'b1;
      end
    end

    // software writes take precedence over hardware updates of the same word
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cmp[g] <= CMP_RST;
      end else if (wr_cmpl[g]) begin
        cmp[g][7:0] <= wr_byte;
      end else if (wr_cmph[g]) begin
        cmp[g][15:8] <= wr_byte;
      end else if (cap) begin
        cmp[g] <= counter_array.value;
      end else if (md == MODE_FREQ && match8) begin
        cmp[g][7:0] <= 8'(cmp[g][7:0] + cmp[g][15:8]);
      end else if (md == MODE_PWM8 && low_wrap) begin
        cmp[g][7:0] <= cmp[g][15:8];
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        module_io_pin_out[g] <= 1'b0;
        module_io_pin_oe_n[g] <= 1'b1;
      end else begin
        module_io_pin_oe_n[g] <= !(md == MODE_HSO || md == MODE_FREQ ||
                                   md == MODE_PWM8 || md == MODE_PWM16);
        case (md)
          MODE_HSO: begin
            if (match16) begin
              module_io_pin_out[g] <= !module_io_pin_out[g];
            end
          end
          MODE_FREQ: begin
            if (match8) begin
              module_io_pin_out[g] <= !module_io_pin_out[g];
            end
          end
          MODE_PWM8: begin
            if (!ecom) begin
              module_io_pin_out[g] <= 1'b0;
            end else if (low_wrap) begin
              // reloaded byte of zero matches at once: full duty
              module_io_pin_out[g] <= (cmp[g][15:8] == LOW_WRAP);
            end else if (match8) begin
              module_io_pin_out[g] <= 1'b1;
            end
          end
          MODE_PWM16: begin
            if (!ecom) begin
              module_io_pin_out[g] <= 1'b0;
            end else if (full_wrap) begin
              module_io_pin_out[g] <= (cmp[g] == COUNT_WRAP);
            end else if (match16) begin
              module_io_pin_out[g] <= 1'b1;
            end
          end
          default: begin
            module_io_pin_out[g] <= module_io_pin_out[g];
          end
        endcase
      end
    end
  end

endmodule // ccm_top

// File: sim/ccm_top_sva.sv
// ccm_top_sva: port-level checks of the capture/compare block.
// assumes one clock domain; bound onto every ccm_top instance.
`timescale 1ns/1ps

module ccm_top_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire ccm_pkg::ccm_axil_req_s bus_req,
  input wire ccm_pkg::ccm_axil_rsp_s bus_rsp,
  // counter and pins
  input wire ccm_pkg::ccm_count_s counter_array,
  input wire logic [ccm_pkg::NUM_MOD-1:0] module_io_pin_out,
  input wire logic [ccm_pkg::NUM_MOD-1:0] module_io_pin_oe_n,
  input wire logic irq_request
);
  import ccm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_take;
    bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready;
  endsequence
  sequence s_wr_done;
    !bus_rsp.awready ##1 bus_rsp.bvalid;
  endsequence
  // two quiet cycles cover a write plus the registered output behind it
  sequence s_bus_quiet;
    bus_rsp.awready && $past(bus_rsp.awready);
  endsequence

  property p_wr_answer;
    s_wr_take |=> s_wr_done;
  endproperty
  property p_rd_answer;
    bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid && !bus_rsp.arready;
  endproperty
  property p_b_hold;
    bus_rsp.bvalid && !bus_req.bready |=> bus_rsp.bvalid && $stable(bus_rsp.bresp);
  endproperty
  property p_r_hold;
    bus_rsp.rvalid && !bus_req.rready |=> bus_rsp.rvalid && $stable(bus_rsp.rdata);
  endproperty
  property p_b_drop;
    bus_rsp.bvalid && bus_req.bready |=> !bus_rsp.bvalid;
  endproperty
  property p_pin_rise;
    |(module_io_pin_out & ~$past(module_io_pin_out)) |-> $past(counter_array.tick);
  endproperty
  property p_irq_hold;
    (irq_request and s_bus_quiet) |=> irq_request;
  endproperty
  property p_oe_hold;
    s_bus_quiet |=> $stable(module_io_pin_oe_n);
  endproperty
  property p_rst_state;
    $rose(rst_n) |-> bus_rsp.awready && !bus_rsp.bvalid && !irq_request
      && (&module_io_pin_oe_n);
  endproperty

  a_wr_answer: assert property (p_wr_answer) else $error("write answer out of step");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  a_b_drop: assert property (p_b_drop) else $error("write response lingers");
  a_pin_rise: assert property (p_pin_rise) else $error("pin rose without tick");
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell with no write");
  a_oe_hold: assert property (p_oe_hold) else $error("pin enable moved alone");
  a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
endmodule // ccm_top_sva

bind ccm_top ccm_top_sva u_sva (
  .clk(clk),
  .rst_n(rst_n),
  .bus_req(bus_req),
  .bus_rsp(bus_rsp),
  .counter_array(counter_array),
  .module_io_pin_out(module_io_pin_out),
  .module_io_pin_oe_n(module_io_pin_oe_n),
  .irq_request(irq_request)
);

// File: sim/ccm_pin_model.sv
// ccm_pin_model: outside world on the five module pins.
// assumes the bench sets wanted levels and orders one-cycle glitches.
`timescale 1ns/1ps

module ccm_pin_model (
  // clock
  input wire logic clk,
  // bench commands
  input wire logic [ccm_pkg::NUM_MOD-1:0] want,
  input wire logic [ccm_pkg::NUM_MOD-1:0] glitch,
  // device side
  input wire logic [ccm_pkg::NUM_MOD-1:0] pin_out,
  input wire logic [ccm_pkg::NUM_MOD-1:0] pin_oe_n,
  output logic [ccm_pkg::NUM_MOD-1:0] pin_in
);
  import ccm_pkg::*;
  logic [NUM_MOD-1:0] lvl = '0;
  logic age = 1'b0;
  // a new level only once the old one has stood two clocks
  always @(posedge clk) begin
    if (want != lvl && age) begin
      lvl <= want;
      age <= 1'b0;
    end else begin
      age <= 1'b1;
    end
  end
  // glitch is the one deliberate breach, a single short pulse
  assign pin_in = (pin_oe_n & (lvl ^ glitch)) | (~pin_oe_n & pin_out);
endmodule // ccm_pin_model

// File: sim/tb_ccm_top.sv
// tb_ccm_top: table and directed checks of the capture/compare block.
// assumes the bench plays bus master and shared counter.
`timescale 1ns/1ps

module tb_ccm_top;
  import ccm_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [1:0] r;
  } ccm_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ccm_axil_req_s req = '0;
  ccm_axil_rsp_s rsp;
  ccm_count_s cnt = '0;
  logic [4:0] want = 5'h00;
  logic [4:0] glitch = 5'h00;
  logic [4:0] pin_in;
  logic [4:0] pin_out;
  logic [4:0] oe_n;
  logic irq;
  int err_total = 0;
  int num_checks = 0;
  ccm_row_s rows [5] = '{'{IRQEN_OFS, 8'h03, 8'h03, RESP_OKAY},
    '{MODE_BASE, 8'h5a, 8'h5a, RESP_OKAY}, '{CMPH_BASE + 8'h10, 8'h7f, 8'h7f, RESP_OKAY},
    '{8'hfc, 8'h12, 8'h00, RESP_SLVERR}, '{CTRL_OFS, 8'h1f, 8'h1f, RESP_OKAY}};

  ccm_top dut (.clk(clk), .rst_n(rst_n), .bus_req(req), .bus_rsp(rsp), .counter_array(cnt),
    .module_io_pin_in(pin_in), .module_io_pin_out(pin_out), .module_io_pin_oe_n(oe_n),
    .irq_request(irq));
  ccm_pin_model u_pins (.clk(clk), .want(want), .glitch(glitch), .pin_out(pin_out),
    .pin_oe_n(oe_n), .pin_in(pin_in));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic give_verdict();
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] ad(input logic [7:0] b, input int n);
    return b + 8'(4 * n);
  endfunction

  task automatic rst();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= 32'(d);
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    if (k == 40) begin
      err_total++;
      give_verdict();
    end
    chk(32'(rsp.bresp), 32'(er));
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] q, input logic [1:0] er);
    int k;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    if (k == 40) begin
      err_total++;
      give_verdict();
    end
    chk(rsp.rdata, 32'(q));
    chk(32'(rsp.rresp), 32'(er));
    req.rready <= 1'b0;
  endtask

  task automatic cmp(input int n, input logic [7:0] lo, input logic [7:0] hi);
    wr(ad(CMPL_BASE, n), lo, RESP_OKAY);
    wr(ad(CMPH_BASE, n), hi, RESP_OKAY);
  endtask

  // one counter advance, then wait out flag and irq latency
  task automatic step(input logic [15:0] v);
    @(posedge clk);
    cnt.value <= v;
    cnt.tick <= 1'b1;
    @(posedge clk);
    cnt.tick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    int i;
    int m;
    logic [7:0] md;
    rst();
    for (i = 0; i < 5; i++) begin
      wr(rows[i].a, rows[i].d, rows[i].r);
      rd(rows[i].a, rows[i].q, rows[i].r);
    end
    rst();
    @(posedge clk);
    chk(32'({oe_n, pin_out, irq}), 32'h0000_07c0);
    for (i = 0; i < 5; i++) rd(rows[i].a, 8'h00, rows[i].r);
    wr(ad(MODE_BASE, 2), 8'h49, RESP_OKAY);
    wr(ad(CMPL_BASE, 2), 8'h34, RESP_OKAY);
    rd(ad(MODE_BASE, 2), 8'h09, RESP_OKAY);
    wr(ad(CMPH_BASE, 2), 8'h12, RESP_OKAY);
    rd(ad(MODE_BASE, 2), 8'h49, RESP_OKAY);
    wr(IRQEN_OFS, 8'h03, RESP_OKAY);
    step(16'h1233);
    rd(CTRL_OFS, 8'h00, RESP_OKAY);
    step(16'h1234);
    rd(CTRL_OFS, 8'h04, RESP_OKAY);
    chk(32'(irq), 32'h1);
    step(16'h1235);
    rd(CTRL_OFS, 8'h04, RESP_OKAY);
    wr(IRQEN_OFS, 8'h01, RESP_OKAY);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(IRQEN_OFS, 8'h03, RESP_OKAY);
    wr(CTRL_OFS, 8'h00, RESP_OKAY);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(ad(MODE_BASE, 3), 8'h4c, RESP_OKAY);
    cmp(3, 8'h05, 8'h00);
    step(16'h0005);
    chk(32'({oe_n[3], pin_out[3]}), 32'h1);
    step(16'h0006);
    chk(32'(pin_out[3]), 32'h1);
    step(16'h0005);
    chk(32'(pin_out[3]), 32'h0);
    wr(ad(MODE_BASE, 0), 8'h42, RESP_OKAY);
    cmp(0, 8'h80, 8'hc0);
    step(16'h0080);
    chk(32'(pin_out[0]), 32'h1);
    step(16'h0100);
    chk(32'(pin_out[0]), 32'h0);
    rd(ad(CMPL_BASE, 0), 8'hc0, RESP_OKAY);
    step(16'h01bf);
    chk(32'(pin_out[0]), 32'h0);
    step(16'h01c0);
    chk(32'(pin_out[0]), 32'h1);
    wr(ad(CMPL_BASE, 0), 8'hc0, RESP_OKAY);
    step(16'h0200);
    step(16'h02c0);
    chk(32'(pin_out[0]), 32'h0);
    wr(ad(MODE_BASE, 4), 8'h46, RESP_OKAY);
    cmp(4, 8'h10, 8'h20);
    step(16'h0310);
    chk(32'(pin_out[4]), 32'h1);
    rd(ad(CMPL_BASE, 4), 8'h30, RESP_OKAY);
    wr(ad(CMPH_BASE, 4), 8'h00, RESP_OKAY);
    step(16'h0330);
    chk(32'(pin_out[4]), 32'h0);
    rd(ad(CMPL_BASE, 4), 8'h30, RESP_OKAY);
    wr(ad(MODE_BASE, 2), 8'hc2, RESP_OKAY);
    step(16'h1234);
    chk(32'(pin_out[2]), 32'h1);
    step(16'h0000);
    chk(32'(pin_out[2]), 32'h0);
    for (m = 0; m < 3; m++) begin
      md = (m == 0) ? 8'h20 : (m == 1) ? 8'h10 : 8'h30;
      wr(ad(MODE_BASE, 1), md, RESP_OKAY);
      wr(CTRL_OFS, 8'h00, RESP_OKAY);
      step(16'h0a00 + 16'(m));
      want <= 5'h02;
      repeat (4) @(posedge clk);
      rd(CTRL_OFS, {6'h00, md[5], 1'b0}, RESP_OKAY);
      wr(CTRL_OFS, 8'h00, RESP_OKAY);
      want <= 5'h00;
      repeat (4) @(posedge clk);
      rd(CTRL_OFS, {6'h00, md[4], 1'b0}, RESP_OKAY);
      rd(ad(CMPL_BASE, 1), 8'(m), RESP_OKAY);
      rd(ad(CMPH_BASE, 1), 8'h0a, RESP_OKAY);
    end
    wr(CTRL_OFS, 8'h00, RESP_OKAY);
    glitch <= 5'h02;
    @(posedge clk);
    glitch <= 5'h00;
    repeat (4) @(posedge clk);
    rd(CTRL_OFS, 8'h00, RESP_OKAY);
    // duty update paced by the match interrupt
    wr(ad(MODE_BASE, 2), 8'hcb, RESP_OKAY);
    step(16'h1234);
    chk(32'(irq), 32'h1);
    chk(32'(pin_out[2]), 32'h1);
    cmp(2, 8'h00, 8'h00);
    wr(CTRL_OFS, 8'h00, RESP_OKAY);
    step(16'h0000);
    chk(32'(pin_out[2]), 32'h1);
    rd(CTRL_OFS, 8'h04, RESP_OKAY);
    cmp(0, 8'h00, 8'h00);
    step(16'h0300);
    chk(32'(pin_out[0]), 32'h1);
    give_verdict();
  end
endmodule // tb_ccm_top
